// ===== design/bdeo_clk_div.sv
// Modulator and chopper tick generator.
// Assumes control values arrive registered on aclk.
`timescale 1ns/1ps
`default_nettype none
module bdeo_clk_div (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    bdeo_div_if.div     dif
);

    logic [4:0] mod_cnt_r;
    logic [4:0] chop_cnt_r;
    logic       mod_tick_r;
    logic       chop_tick_r;
    logic [4:0] mod_lim;
    logic [4:0] chop_lim;

    assign mod_lim       = bdeo_pkg::mod_ratio(dif.mod_div_sel);
    assign chop_lim      = bdeo_pkg::chop_ratio(dif.chop_code);
    assign dif.mod_tick  = mod_tick_r;
    assign dif.chop_tick = chop_tick_r;

    // ------------------------------------------------------------------
    // Modulator clock
    // ------------------------------------------------------------------
    // Wrap on >= so a shrinking ratio never strands the counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mod_cnt_r  <= 5'h00;
            mod_tick_r <= 1'b0;
        end else if (mod_cnt_r >= mod_lim - 5'h01) begin
            mod_cnt_r  <= 5'h00;
            mod_tick_r <= 1'b1;
        end else begin
            mod_cnt_r  <= mod_cnt_r + 5'h01;
            mod_tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Chopper clock, counted in modulator ticks
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chop_cnt_r  <= 5'h00;
            chop_tick_r <= 1'b0;
        end else if (mod_tick_r) begin
            if (chop_cnt_r >= chop_lim - 5'h01) begin
                chop_cnt_r  <= 5'h00;
                chop_tick_r <= 1'b1;
            end else begin
                chop_cnt_r  <= chop_cnt_r + 5'h01;
                chop_tick_r <= 1'b0;
            end
        end else begin
            chop_tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [4:0] mod_gap_r;
    logic [4:0] chop_gap_r;
    logic       mod_ok_r;
    logic       chop_ok_r;
    logic       sel_q_r;
    logic [1:0] code_q_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mod_gap_r  <= 5'h00;
            chop_gap_r <= 5'h00;
            mod_ok_r   <= 1'b0;
            chop_ok_r  <= 1'b0;
            sel_q_r    <= 1'b0;
            code_q_r   <= 2'h0;
        end else begin
            sel_q_r  <= dif.mod_div_sel;
            code_q_r <= dif.chop_code;
            mod_gap_r <= mod_tick_r ? 5'h01 : mod_gap_r + 5'h01;
            if (sel_q_r != dif.mod_div_sel)
                mod_ok_r <= 1'b0;
            else if (mod_tick_r)
                mod_ok_r <= 1'b1;
            if (chop_tick_r)
                chop_gap_r <= 5'h00;
            else if (mod_tick_r)
                chop_gap_r <= chop_gap_r + 5'h01;
            if (code_q_r != dif.chop_code || sel_q_r != dif.mod_div_sel)
                chop_ok_r <= 1'b0;
            else if (chop_tick_r)
                chop_ok_r <= 1'b1;
        end
    end

    AST_MOD_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
        mod_tick_r && mod_ok_r && sel_q_r == dif.mod_div_sel |-> mod_gap_r == mod_lim)
        else $error("modulator tick period does not match divider select");

    AST_CHOP_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
        mod_tick_r && chop_ok_r && code_q_r == dif.chop_code && chop_gap_r == chop_lim - 5'h01
        |=> chop_tick_r)
        else $error("chopper tick missing after selected count of modulator ticks");

endmodule
`default_nettype wire

// ===== design/bdeo_div_if.sv
// Divider control and tick outputs between the register bank and its divider.
// Assumes both ends share aclk.
`timescale 1ns/1ps
`default_nettype none
interface bdeo_div_if;
    logic       mod_div_sel;
    logic [1:0] chop_code;
    logic       mod_tick;
    logic       chop_tick;

    modport ctrl (output mod_div_sel, output chop_code, input mod_tick, input chop_tick);
    modport div  (input mod_div_sel, input chop_code, output mod_tick, output chop_tick);
endinterface
`default_nettype wire

// ===== design/bdeo_pkg.sv
// Constants for the bias-drive and electrode-off register bank.
// Assumes a single clock domain at 200 MHz and an AXI4-Lite register port.
package bdeo_pkg;

    localparam int          REG_W          = 8;
    localparam int          ADDR_W         = 8;
    localparam int          DET_W          = 5;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0]  IDX_BIAS       = 6'h06;
    localparam logic [5:0]  IDX_EOFF       = 6'h07;
    localparam logic [5:0]  IDX_STAT       = 6'h08;
    localparam logic [5:0]  IDX_IRQ_STAT   = 6'h0c;
    localparam logic [5:0]  IDX_IRQ_MASK   = 6'h0d;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          CHOP_LSB       = 6;
    localparam int          BIAS_PWR_BIT   = 5;
    localparam int          BIAS_SENSE_BIT = 4;
    localparam int          CH2_EXCITE_REVERSE_BIT      = 5;
    localparam int          CH1_EXCITE_REVERSE_BIT      = 4;
    localparam int          CLKDIV_BIT     = 6;
    localparam int          BIAS_DET_BIT   = 4;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0]  BIAS_RST       = 8'h00;
    localparam logic [7:0]  EOFF_RST       = 8'h00;
    localparam logic [7:0]  EOFF_WMASK     = 8'h3f;
    localparam logic        CLKDIV_RST     = 1'b0;
    localparam logic [4:0]  DET_RST        = 5'h00;

    // ------------------------------------------------------------------
    // Divider codes and ratios
    // ------------------------------------------------------------------
    localparam logic [1:0]  CHOP_DIV16     = 2'h0;
    localparam logic [1:0]  CHOP_RSVD      = 2'h1;
    localparam logic [1:0]  CHOP_DIV2      = 2'h2;
    localparam logic [1:0]  CHOP_DIV4      = 2'h3;
    localparam logic [4:0]  MOD_RATIO_LO   = 5'h04;
    localparam logic [4:0]  MOD_RATIO_HI   = 5'h10;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Reserved chop code falls back to the slowest rate
    function automatic logic [4:0] chop_ratio(input logic [1:0] code);
        unique case (code)
            CHOP_DIV2:  chop_ratio = 5'h02;
            CHOP_DIV4:  chop_ratio = 5'h04;
            default:    chop_ratio = 5'h10;
        endcase
    endfunction

    function automatic logic [4:0] mod_ratio(input logic sel);
        mod_ratio = sel ? MOD_RATIO_HI : MOD_RATIO_LO;
    endfunction

endpackage

// ===== design/bdeo_regs.sv
// Bias-drive and electrode-off register bank with AXI4-Lite slave port.
// Assumes electrode detect levels arrive asynchronously from analog comparators.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Chop code selects modulator divided 16, 2, 4
// - Bias buffer powered only when bit set
// - Bias electrode sensing enabled by bit four
// - Low bits route inputs into bias derivation
// - Flip bits reverse excitation current per channel
// - Low bits enable per-input detach detection
// - Status reads one when electrode detached
// - Divider bit picks modulator ratio four/sixteen
// - Bias detached flag is read only
// - Channel detached flags are read only
module bdeo_regs (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [4:0]  detached_raw,
    output logic             bias_buffer_power_on,
    output logic             bias_electrode_sense_enable,
    output logic             bias_src_ch2_neg,
    output logic             bias_src_ch2_pos,
    output logic             bias_src_ch1_neg,
    output logic             bias_src_ch1_pos,
    output logic             ch2_excite_reverse,
    output logic             ch1_excite_reverse,
    output logic             detach_detect_ch2_neg,
    output logic             detach_detect_ch2_pos,
    output logic             detach_detect_ch1_neg,
    output logic             detach_detect_ch1_pos,
    output logic             modulator_clock,
    output logic             chop_clock,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a[1:0] == 2'h0) &&
                   (a[7:2] == bdeo_pkg::IDX_BIAS || a[7:2] == bdeo_pkg::IDX_EOFF ||
                    a[7:2] == bdeo_pkg::IDX_STAT || a[7:2] == bdeo_pkg::IDX_IRQ_STAT ||
                    a[7:2] == bdeo_pkg::IDX_IRQ_MASK);
    endfunction

    logic [7:0] bias_r;
    logic [7:0] eoff_r;
    logic       clkdiv_r;
    logic [4:0] det_s1_r;
    logic [4:0] det_s2_r;
    logic [4:0] det_q_r;
    logic [4:0] irq_stat_r;
    logic [4:0] irq_mask_r;
    logic       irq_r;

    logic       aw_held_r;
    logic       w_held_r;
    logic [7:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic       w_lane0_r;
    logic       awready_r;
    logic       wready_r;
    logic       bvalid_r;
    logic [1:0] bresp_r;
    logic       arready_r;
    logic       rvalid_r;
    logic [7:0] rdata_r;
    logic [1:0] rresp_r;

    logic       aw_take;
    logic       w_take;
    logic       ar_take;
    logic       wr_fire;
    logic       wr_en;
    logic [5:0] wr_idx;
    logic       aw_held_nxt;
    logic       w_held_nxt;
    logic       bvalid_nxt;
    logic       rvalid_nxt;
    logic [7:0] stat_view;
    logic [4:0] det_en;
    logic [4:0] det_rise;
    logic [4:0] irq_clr;

    bdeo_div_if dif ();

    // ------------------------------------------------------------------
    // Write channel handshake
    // ------------------------------------------------------------------
    always_comb begin
        aw_take     = s_axi_awvalid && awready_r;
        w_take      = s_axi_wvalid && wready_r;
        ar_take     = s_axi_arvalid && arready_r;
        wr_fire     = aw_held_r && w_held_r && !bvalid_r;
        wr_en       = wr_fire && w_lane0_r && addr_hit(aw_addr_r);
        wr_idx      = aw_addr_r[7:2];
        aw_held_nxt = !wr_fire && (aw_held_r || aw_take);
        w_held_nxt  = !wr_fire && (w_held_r || w_take);
        bvalid_nxt  = wr_fire || (bvalid_r && !s_axi_bready);
        rvalid_nxt  = ar_take || (rvalid_r && !s_axi_rready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= bdeo_pkg::RESP_OKAY;
            aw_addr_r <= 8'h00;
            w_data_r  <= 8'h00;
            w_lane0_r <= 1'b0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awready_r <= !aw_held_nxt && !bvalid_nxt;
            wready_r  <= !w_held_nxt && !bvalid_nxt;
            bvalid_r  <= bvalid_nxt;
            if (aw_take)
                aw_addr_r <= s_axi_awaddr;
            if (w_take) begin
                w_data_r  <= s_axi_wdata[7:0];
                w_lane0_r <= s_axi_wstrb[0];
            end
            if (wr_fire)
                bresp_r <= addr_hit(aw_addr_r) ? bdeo_pkg::RESP_OKAY : bdeo_pkg::RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    assign stat_view = {1'b0, clkdiv_r, 1'b0, det_s2_r};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 8'h00;
            rresp_r   <= bdeo_pkg::RESP_OKAY;
        end else begin
            arready_r <= !rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            if (ar_take) begin
                rresp_r <= addr_hit(s_axi_araddr) ? bdeo_pkg::RESP_OKAY
                                                  : bdeo_pkg::RESP_SLVERR;
                if (s_axi_araddr[1:0] != 2'h0)
                    rdata_r <= 8'h00;
                else if (s_axi_araddr[7:2] == bdeo_pkg::IDX_BIAS)
                    rdata_r <= bias_r;
                else if (s_axi_araddr[7:2] == bdeo_pkg::IDX_EOFF)
                    rdata_r <= eoff_r;
                else if (s_axi_araddr[7:2] == bdeo_pkg::IDX_STAT)
                    rdata_r <= stat_view;
                else if (s_axi_araddr[7:2] == bdeo_pkg::IDX_IRQ_STAT)
                    rdata_r <= {3'h0, irq_stat_r};
                else if (s_axi_araddr[7:2] == bdeo_pkg::IDX_IRQ_MASK)
                    rdata_r <= {3'h0, irq_mask_r};
                else
                    rdata_r <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            bias_r <= bdeo_pkg::BIAS_RST;
        else if (wr_en && wr_idx == bdeo_pkg::IDX_BIAS)
            bias_r <= w_data_r;
    end

    // Top two bits are tied low so they read back as zero
    always_ff @(posedge aclk) begin
        if (!aresetn)
            eoff_r <= bdeo_pkg::EOFF_RST;
        else if (wr_en && wr_idx == bdeo_pkg::IDX_EOFF)
            eoff_r <= w_data_r & bdeo_pkg::EOFF_WMASK;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            clkdiv_r <= bdeo_pkg::CLKDIV_RST;
        else if (wr_en && wr_idx == bdeo_pkg::IDX_STAT)
            clkdiv_r <= w_data_r[bdeo_pkg::CLKDIV_BIT];
    end

    // ------------------------------------------------------------------
    // Electrode detach status
    // ------------------------------------------------------------------
    // Status is a live level, not latched: it follows the comparators
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            det_s1_r <= bdeo_pkg::DET_RST;
            det_s2_r <= bdeo_pkg::DET_RST;
            det_q_r  <= bdeo_pkg::DET_RST;
        end else begin
            det_s1_r <= detached_raw;
            det_s2_r <= det_s1_r;
            det_q_r  <= det_s2_r;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // Only enabled inputs raise events, since other status bits are noise
    assign det_en   = {bias_r[bdeo_pkg::BIAS_SENSE_BIT], eoff_r[3:0]};
    assign det_rise = det_s2_r & ~det_q_r & det_en;
    assign irq_clr  = (wr_en && wr_idx == bdeo_pkg::IDX_IRQ_STAT) ? w_data_r[4:0] : 5'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= 5'h00;
            irq_mask_r <= 5'h00;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | det_rise;
            if (wr_en && wr_idx == bdeo_pkg::IDX_IRQ_MASK)
                irq_mask_r <= w_data_r[4:0];
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Divider and outputs
    // ------------------------------------------------------------------
    assign dif.mod_div_sel = clkdiv_r;
    assign dif.chop_code   = bias_r[bdeo_pkg::CHOP_LSB +: 2];

    bdeo_clk_div u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dif     (dif)
    );

    assign s_axi_awready               = awready_r;
    assign s_axi_wready                = wready_r;
    assign s_axi_bvalid                = bvalid_r;
    assign s_axi_bresp                 = bresp_r;
    assign s_axi_arready               = arready_r;
    assign s_axi_rvalid                = rvalid_r;
    assign s_axi_rresp                 = rresp_r;
    assign s_axi_rdata                 = {24'h000000, rdata_r};
    assign bias_buffer_power_on        = bias_r[bdeo_pkg::BIAS_PWR_BIT];
    assign bias_electrode_sense_enable = bias_r[bdeo_pkg::BIAS_SENSE_BIT];
    assign bias_src_ch2_neg            = bias_r[3];
    assign bias_src_ch2_pos            = bias_r[2];
    assign bias_src_ch1_neg            = bias_r[1];
    assign bias_src_ch1_pos            = bias_r[0];
    assign ch2_excite_reverse          = eoff_r[bdeo_pkg::CH2_EXCITE_REVERSE_BIT];
    assign ch1_excite_reverse          = eoff_r[bdeo_pkg::CH1_EXCITE_REVERSE_BIT];
    assign detach_detect_ch2_neg       = eoff_r[3];
    assign detach_detect_ch2_pos       = eoff_r[2];
    assign detach_detect_ch1_neg       = eoff_r[1];
    assign detach_detect_ch1_pos       = eoff_r[0];
    assign modulator_clock             = dif.mod_tick;
    assign chop_clock                  = dif.chop_tick;
    assign irq                         = irq_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_BIAS_PWR: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx == bdeo_pkg::IDX_BIAS |=> s_axi_bvalid &&
        bias_buffer_power_on == $past(w_data_r[5]))
        else $error("bias buffer power does not follow written bit");

    AST_BIAS_SENSE: assert property (@(posedge aclk) disable iff (!aresetn)
        !(wr_en && wr_idx == bdeo_pkg::IDX_BIAS) |=> $stable(bias_electrode_sense_enable))
        else $error("bias sense enable changed without a write");

    AST_BIAS_SRC: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx == bdeo_pkg::IDX_BIAS |=>
        {bias_src_ch2_neg, bias_src_ch2_pos, bias_src_ch1_neg, bias_src_ch1_pos}
        == $past(w_data_r[3:0]))
        else $error("bias source routing does not follow written bits");

    AST_FLIP: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx == bdeo_pkg::IDX_EOFF |=>
        {ch2_excite_reverse, ch1_excite_reverse} == $past(w_data_r[5:4]) && eoff_r[7:6] == 2'h0)
        else $error("excitation reverse bits wrong after write");

    AST_DETECT_EN: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx != bdeo_pkg::IDX_EOFF |=> $stable({detach_detect_ch2_neg,
        detach_detect_ch2_pos, detach_detect_ch1_neg, detach_detect_ch1_pos}))
        else $error("detection enables changed by a foreign write");

    AST_STAT_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && s_axi_araddr == {bdeo_pkg::IDX_STAT, 2'h0} |=>
        s_axi_rvalid && s_axi_rdata[4:0] == $past(det_s2_r))
        else $error("status read does not show detach levels");

    AST_BIAS_STAT: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn, 1) && $past(aresetn, 2) |->
        det_s2_r[bdeo_pkg::BIAS_DET_BIT] == $past(detached_raw[bdeo_pkg::BIAS_DET_BIT], 2))
        else $error("bias detach flag not two cycles behind input");

    AST_CH_STAT: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn, 1) && $past(aresetn, 2) |-> det_s2_r[3:0] == $past(detached_raw[3:0], 2))
        else $error("channel detach flags not two cycles behind input");

    AST_STAT_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx == bdeo_pkg::IDX_STAT |=>
        clkdiv_r == $past(w_data_r[6]) && det_s2_r == $past(det_s1_r))
        else $error("status write altered read-only bits or missed divider bit");

    AST_DIV_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(clkdiv_r) |-> $past(wr_en) && $past(wr_idx) == bdeo_pkg::IDX_STAT)
        else $error("divider select changed without a status write");

    AST_CHOP_CODE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx == bdeo_pkg::IDX_BIAS |=> dif.chop_code == $past(w_data_r[7:6]))
        else $error("chop code does not follow written bias bits");

endmodule
`default_nettype wire

// ===== dv/bdeo_tb.sv
// Self-checking bench for the bias-drive and electrode-off register bank.
// Assumes the bank alone on one 200 MHz clock, driven over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, irq, modulator_clock, chop_clock;
    logic        bias_buffer_power_on, bias_electrode_sense_enable, bias_src_ch2_neg;
    logic        bias_src_ch2_pos, bias_src_ch1_neg, bias_src_ch1_pos, ch2_excite_reverse;
    logic        ch1_excite_reverse, detach_detect_ch2_neg, detach_detect_ch2_pos;
    logic        detach_detect_ch1_neg, detach_detect_ch1_pos;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [4:0]  detached_raw;
    int          n_fail, n_tests;
    int          cr[4] = '{16, 16, 2, 4};

    bdeo_regs bdeo_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .detached_raw,
        .bias_buffer_power_on, .bias_electrode_sense_enable, .bias_src_ch2_neg,
        .bias_src_ch2_pos, .bias_src_ch1_neg, .bias_src_ch1_pos, .ch2_excite_reverse,
        .ch1_excite_reverse, .detach_detect_ch2_neg, .detach_detect_ch2_pos,
        .detach_detect_ch1_neg, .detach_detect_ch1_pos, .modulator_clock, .chop_clock, .irq);

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Write and check the response code; address and data released as each is taken
    task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
    endtask

    // Skips two ticks so a divider change has wrapped before the period is counted
    task automatic per(input bit s, input int e);
        int n;
        repeat (2) do @(posedge aclk); while (!(s ? chop_clock : modulator_clock));
        n = 0;
        do begin @(posedge aclk); n++; end while (!(s ? chop_clock : modulator_clock));
        chk(32'(n), 32'(e));
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    initial begin
        #100us;
        n_fail++;
        close_out();
    end

    initial begin
        aresetn = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00;
        s_axi_awprot = 3'h0; s_axi_arprot = 3'h0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'h1;
        detached_raw = 5'h00;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rc(8'h18, 32'h0, 2'h0);
        rc(8'h1c, 32'h0, 2'h0);
        rc(8'h20, 32'h0, 2'h0);
        $display("reset values done");
        wc(8'h18, 32'h29, 2'h0);
        chk(32'({bias_buffer_power_on, bias_electrode_sense_enable, bias_src_ch2_neg,
            bias_src_ch2_pos, bias_src_ch1_neg, bias_src_ch1_pos}), 32'h29);
        wc(8'h1c, 32'hd6, 2'h0);
        rc(8'h1c, 32'h16, 2'h0);
        chk(32'({ch2_excite_reverse, ch1_excite_reverse, detach_detect_ch2_neg,
            detach_detect_ch2_pos, detach_detect_ch1_neg, detach_detect_ch1_pos}), 32'h16);
        // A write with lane 0 disabled is answered but must store nothing
        s_axi_wstrb <= 4'h0;
        wc(8'h1c, 32'h3f, 2'h0);
        s_axi_wstrb <= 4'h1;
        rc(8'h1c, 32'h16, 2'h0);
        wc(8'h40, 32'h1, 2'h2);
        rc(8'h19, 32'h0, 2'h2);
        $display("config registers done");
        wc(8'h20, 32'hff, 2'h0);
        rc(8'h20, 32'h40, 2'h0);
        per(1'b0, 16);
        wc(8'h20, 32'h0, 2'h0);
        per(1'b0, 4);
        for (int i = 0; i < 4; i++) begin
            wc(8'h18, 32'(i << 6), 2'h0);
            per(1'b1, 4 * cr[i]);
        end
        $display("dividers done");
        wc(8'h18, 32'h10, 2'h0);
        wc(8'h1c, 32'h0f, 2'h0);
        detached_raw <= 5'h1f;
        repeat (6) @(posedge aclk);
        rc(8'h20, 32'h1f, 2'h0);
        chk(32'(irq), 32'h0);
        rc(8'h30, 32'h1f, 2'h0);
        wc(8'h34, 32'h1f, 2'h0);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
        wc(8'h30, 32'h1f, 2'h0);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        detached_raw <= 5'h00;
        repeat (4) @(posedge aclk);
        rc(8'h20, 32'h0, 2'h0);
        $display("detach and interrupt done");
        close_out();
    end
endmodule
`default_nettype wire
